// [include/mcpwm_pkg.sv]
/*
 Shared constants and types for the motor PWM block: register indices, field positions,
 reset values, unlock keys and the register-access request carrier.
 Assumes a 16-bit special-function-register port driven synchronously to sys_clk.
*/
package mcpwm_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W  = 15;
  localparam int unsigned NPAIR  = 3;

  // Register indices
  localparam logic [3:0] A_TB_CTRL  = 4'h0;
  localparam logic [3:0] A_TB_COUNT = 4'h1;
  localparam logic [3:0] A_TB_PER   = 4'h2;
  localparam logic [3:0] A_CON_ONE  = 4'h3;
  localparam logic [3:0] A_FLT_A    = 4'h4;
  localparam logic [3:0] A_FLT_B    = 4'h5;
  localparam logic [3:0] A_KEY      = 4'h6;
  localparam logic [3:0] A_DUTY1    = 4'h7;
  localparam logic [3:0] A_DUTY2    = 4'h8;
  localparam logic [3:0] A_DUTY3    = 4'h9;
  localparam logic [3:0] A_STATUS   = 4'ha;

  // Time base control fields
  localparam int unsigned TB_EN_BIT   = 15;
  localparam int unsigned TB_IDLE_BIT = 13;
  localparam int unsigned TB_POST_LSB = 4;
  localparam int unsigned TB_PRE_LSB  = 2;
  localparam int unsigned TB_MODE_LSB = 0;
  localparam logic [15:0] TB_CTRL_MASK = 16'ha0ff;

  localparam logic [1:0] MODE_FREE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;

  // Control register one fields
  localparam int unsigned CON_PMOD_LSB = 8;
  localparam int unsigned CON_PENH_LSB = 4;
  localparam int unsigned CON_PENL_LSB = 0;
  localparam logic [15:0] CON_ONE_MASK = 16'h0777;
  localparam logic [15:0] CON_ONE_RST  = 16'h0000;

  // Fault control fields
  localparam int unsigned FLT_EN_BIT   = 0;
  localparam int unsigned FLT_CBC_BIT  = 7;
  localparam int unsigned FLT_OVH_LSB  = 8;
  localparam int unsigned FLT_OVL_LSB  = 12;
  localparam logic [15:0] FLT_MASK     = 16'h7781;
  localparam logic [15:0] FLT_RST      = 16'h0001;

  // Status fields
  localparam int unsigned ST_FLAG_A = 0;
  localparam int unsigned ST_FLAG_B = 1;
  localparam int unsigned ST_ACT_A  = 2;
  localparam int unsigned ST_ACT_B  = 3;
  localparam int unsigned ST_ARMED  = 4;

  // Lock configuration bit and unlock keys
  localparam int unsigned  LOCK_CFG_BIT = 6;
  localparam logic [15:0]  KEY_FIRST    = 16'habcd;
  localparam logic [15:0]  KEY_SECOND   = 16'h4321;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mcpwm_sfr_req_t;

endpackage : mcpwm_pkg

// [rtl/mcpwm_unlock.sv]
/*
 Key-sequence gate for the write-protected registers.
 Assumes one register access at most per cycle, presented by the main PWM module.
*/
`timescale 1ns/1ns
module mcpwm_unlock (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire mcpwm_pkg::mcpwm_sfr_req_t req,
  input  wire logic                  prot_addr,
  output logic                       allow,
  output logic                       armed
);

  typedef enum logic [1:0] {
    MCPWM_IDLE,
    MCPWM_KEY1,
    MCPWM_ARMED
  } mcpwm_ulk_state_t;

  typedef struct packed {
    mcpwm_ulk_state_t st;
  } mcpwm_ulk_t;

  mcpwm_ulk_t s_q;
  mcpwm_ulk_t s_d;
  logic       acc;
  logic       key_wr;

  assign acc    = req.wr | req.rd;
  assign key_wr = req.wr & (req.addr == mcpwm_pkg::A_KEY);
  assign allow  = (s_q.st == MCPWM_ARMED) & req.wr & prot_addr;
  assign armed  = (s_q.st == MCPWM_ARMED);

  always_comb begin
    s_d = s_q;
    if (acc) begin
      unique case (s_q.st)
        MCPWM_IDLE: begin
          s_d.st = (key_wr && req.wdata == mcpwm_pkg::KEY_FIRST) ? MCPWM_KEY1 : MCPWM_IDLE;
        end
        MCPWM_KEY1: begin
          if (key_wr && req.wdata == mcpwm_pkg::KEY_SECOND) begin
            s_d.st = MCPWM_ARMED;
          end else if (key_wr && req.wdata == mcpwm_pkg::KEY_FIRST) begin
            s_d.st = MCPWM_KEY1;
          end else begin
            s_d.st = MCPWM_IDLE;
          end
        end
        MCPWM_ARMED: begin
          s_d.st = (key_wr && req.wdata == mcpwm_pkg::KEY_FIRST) ? MCPWM_KEY1 : MCPWM_IDLE;
        end
        default: begin
          s_d.st = MCPWM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q.st <= MCPWM_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : mcpwm_unlock

// [rtl/mcpwm_core.sv]
/*
 Six-output motor PWM with time base, fault forcing and write-protected control registers.
 Assumes register accesses, fault pins and the configuration word are synchronous to sys_clk.
*/
// Operation
// - Three duty generators each drive one high/low output pair, six outputs in all.
// - In complementary mode the low output of a pair is the inverse of its high output, except while a fault forces the outputs.
// - Either enabled fault input, when asserted, forces the outputs to their safe state.
// - During any reset the block keeps ownership of both fault pins.
// - After reset both fault inputs are enabled in latched mode.
// - Normal drive returns only at the next period or half-period boundary after the fault clears.
// - Control register one and both fault control registers are write-protected.
// - Configuration bit 6 enables protection when 1 and removes it when 0.
// - An unlock is a write of 0xabcd then 0x4321 to the key register.
// - The protected write must be the very next register access after the two key writes.
// - Each unlock grants one protected write only.
// - The postscaler divides period events by 1 to 16 before the time base event.
// - With idle-stop set the time base halts in idle mode; otherwise it keeps running.
`timescale 1ns/1ns
module mcpwm_core #(
  parameter int unsigned NPAIR = mcpwm_pkg::NPAIR
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire mcpwm_pkg::mcpwm_sfr_req_t  sfr_req,
  output logic [mcpwm_pkg::DATA_W-1:0]    sfr_rdata,
  input  wire logic [15:0]                oscillator_select_config_word,
  input  wire logic                       cpu_idle,
  input  wire logic                       fault_input_a_n,
  input  wire logic                       fault_input_b_n,
  output logic                            fault_pins_owned,
  output logic [NPAIR-1:0]                high_side_output,
  output logic [NPAIR-1:0]                low_side_output,
  output logic [NPAIR-1:0]                high_side_enable,
  output logic [NPAIR-1:0]                low_side_enable,
  output logic                            time_base_event
);

  localparam int unsigned CW = mcpwm_pkg::CNT_W;

  typedef struct packed {
    logic [15:0]            tb_ctrl;
    logic [CW-1:0]          per;
    logic [15:0]            con_one;
    logic [15:0]            flt_a;
    logic [15:0]            flt_b;
    logic [NPAIR-1:0][CW-1:0] duty;
    logic [CW-1:0]          cnt;
    logic                   down;
    logic [5:0]             pre;
    logic [3:0]             post;
    logic                   flag_a;
    logic                   flag_b;
    logic                   act_a;
    logic                   act_b;
    logic [NPAIR-1:0]       hi;
    logic [NPAIR-1:0]       lo;
    logic [15:0]            rdata;
    logic                   tb_evt;
  } mcpwm_state_t;

  mcpwm_state_t s_q;
  mcpwm_state_t s_d;
  logic         allow;
  logic         armed;
  logic         prot_addr;
  logic         prot_ok;

  function automatic logic [5:0] pre_limit(input logic [1:0] code);
    unique case (code)
      2'h0: pre_limit = 6'h00;
      2'h1: pre_limit = 6'h03;
      2'h2: pre_limit = 6'h0f;
      2'h3: pre_limit = 6'h3f;
    endcase
  endfunction : pre_limit

  function automatic logic wr_at(input mcpwm_pkg::mcpwm_sfr_req_t r, input logic [3:0] a);
    wr_at = r.wr & (r.addr == a);
  endfunction : wr_at

  assign prot_addr = (sfr_req.addr == mcpwm_pkg::A_CON_ONE) | (sfr_req.addr == mcpwm_pkg::A_FLT_A) |
                     (sfr_req.addr == mcpwm_pkg::A_FLT_B);
  assign prot_ok = ~oscillator_select_config_word[mcpwm_pkg::LOCK_CFG_BIT] | allow;

  mcpwm_unlock u_unlock (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .req       (sfr_req),
    .prot_addr (prot_addr),
    .allow     (allow),
    .armed     (armed)
  );

  assign fault_pins_owned = rst | s_q.flt_a[mcpwm_pkg::FLT_EN_BIT] | s_q.flt_b[mcpwm_pkg::FLT_EN_BIT];
  assign high_side_output = s_q.hi;
  assign low_side_output  = s_q.lo;
  assign high_side_enable = s_q.con_one[mcpwm_pkg::CON_PENH_LSB +: NPAIR];
  assign low_side_enable  = s_q.con_one[mcpwm_pkg::CON_PENL_LSB +: NPAIR];
  assign sfr_rdata        = s_q.rdata;
  assign time_base_event  = s_q.tb_evt;

  always_comb begin
    logic       run;
    logic       tick;
    logic       updown;
    logic       bnd;
    logic       per_evt;
    logic       asrt_a;
    logic       asrt_b;
    logic       clr_a;
    logic       clr_b;
    logic [15:0] ovr;
    logic [NPAIR-1:0] cmp;
    s_d      = s_q;
    bnd      = 1'b0;
    asrt_a   = 1'b0;
    asrt_b   = 1'b0;
    clr_a    = 1'b0;
    clr_b    = 1'b0;
    ovr      = 16'h0000;
    cmp      = '0;
    per_evt  = 1'b0;
    s_d.tb_evt = 1'b0;
    updown   = s_q.tb_ctrl[mcpwm_pkg::TB_MODE_LSB + 1];
    run      = s_q.tb_ctrl[mcpwm_pkg::TB_EN_BIT] & ~(cpu_idle & s_q.tb_ctrl[mcpwm_pkg::TB_IDLE_BIT]);
    tick     = run & (s_q.pre == pre_limit(s_q.tb_ctrl[mcpwm_pkg::TB_PRE_LSB +: 2]));

    // Time base
    if (run) begin
      s_d.pre = tick ? 6'h00 : s_q.pre + 6'h01;
    end
    if (tick) begin
      if (!updown) begin
        if (s_q.cnt >= s_q.per) begin
          s_d.cnt = '0;
          bnd     = 1'b1;
          per_evt = 1'b1;
          if (s_q.tb_ctrl[mcpwm_pkg::TB_MODE_LSB +: 2] == mcpwm_pkg::MODE_SINGLE) begin
            s_d.tb_ctrl[mcpwm_pkg::TB_EN_BIT] = 1'b0;
          end
        end else begin
          s_d.cnt = s_q.cnt + CW'(1);
        end
      end else if (!s_q.down) begin
        if (s_q.cnt >= s_q.per) begin
          s_d.down = 1'b1;
          s_d.cnt  = (s_q.cnt == '0) ? '0 : s_q.cnt - CW'(1);
          bnd      = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + CW'(1);
        end
      end else begin
        if (s_q.cnt == '0) begin
          s_d.down = 1'b0;
          s_d.cnt  = CW'(1);
          bnd      = 1'b1;
          per_evt  = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - CW'(1);
        end
      end
    end
    if (per_evt) begin
      if (s_q.post == s_q.tb_ctrl[mcpwm_pkg::TB_POST_LSB +: 4]) begin
        s_d.post   = 4'h0;
        s_d.tb_evt = 1'b1;
      end else begin
        s_d.post = s_q.post + 4'h1;
      end
    end

    // Faults, pins active low
    asrt_a = s_q.flt_a[mcpwm_pkg::FLT_EN_BIT] & ~fault_input_a_n;
    asrt_b = s_q.flt_b[mcpwm_pkg::FLT_EN_BIT] & ~fault_input_b_n;
    clr_a  = wr_at(sfr_req, mcpwm_pkg::A_STATUS) & sfr_req.wdata[mcpwm_pkg::ST_FLAG_A];
    clr_b  = wr_at(sfr_req, mcpwm_pkg::A_STATUS) & sfr_req.wdata[mcpwm_pkg::ST_FLAG_B];
    s_d.flag_a = asrt_a | (s_q.flag_a & ~clr_a);
    s_d.flag_b = asrt_b | (s_q.flag_b & ~clr_b);
    if (asrt_a) begin
      s_d.act_a = 1'b1;
    end else if (bnd && (s_q.flt_a[mcpwm_pkg::FLT_CBC_BIT] || !s_q.flag_a)) begin
      s_d.act_a = 1'b0;
    end
    if (asrt_b) begin
      s_d.act_b = 1'b1;
    end else if (bnd && (s_q.flt_b[mcpwm_pkg::FLT_CBC_BIT] || !s_q.flag_b)) begin
      s_d.act_b = 1'b0;
    end

    // Outputs
    ovr = s_q.act_a ? s_q.flt_a : s_q.flt_b;
    for (int i = 0; i < NPAIR; i++) begin
      cmp[i] = s_q.tb_ctrl[mcpwm_pkg::TB_EN_BIT] & (s_q.cnt < s_q.duty[i]);
      if (s_q.act_a || s_q.act_b) begin
        s_d.hi[i] = ovr[mcpwm_pkg::FLT_OVH_LSB + i];
        s_d.lo[i] = ovr[mcpwm_pkg::FLT_OVL_LSB + i];
      end else begin
        s_d.hi[i] = cmp[i];
        s_d.lo[i] = s_q.con_one[mcpwm_pkg::CON_PMOD_LSB + i] ? cmp[i] : ~cmp[i];
      end
    end

    // Register writes
    if (wr_at(sfr_req, mcpwm_pkg::A_TB_CTRL)) begin
      s_d.tb_ctrl = sfr_req.wdata & mcpwm_pkg::TB_CTRL_MASK;
    end
    if (wr_at(sfr_req, mcpwm_pkg::A_TB_COUNT)) begin
      s_d.cnt = sfr_req.wdata[CW-1:0];
    end
    if (wr_at(sfr_req, mcpwm_pkg::A_TB_PER)) begin
      s_d.per = sfr_req.wdata[CW-1:0];
    end
    if (wr_at(sfr_req, mcpwm_pkg::A_CON_ONE) && prot_ok) begin
      s_d.con_one = sfr_req.wdata & mcpwm_pkg::CON_ONE_MASK;
    end
    if (wr_at(sfr_req, mcpwm_pkg::A_FLT_A) && prot_ok) begin
      s_d.flt_a = sfr_req.wdata & mcpwm_pkg::FLT_MASK;
    end
    if (wr_at(sfr_req, mcpwm_pkg::A_FLT_B) && prot_ok) begin
      s_d.flt_b = sfr_req.wdata & mcpwm_pkg::FLT_MASK;
    end
    for (int i = 0; i < NPAIR; i++) begin
      if (wr_at(sfr_req, mcpwm_pkg::A_DUTY1 + 4'(i))) begin
        s_d.duty[i] = sfr_req.wdata[CW-1:0];
      end
    end

    // Register reads
    s_d.rdata = 16'h0000;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        mcpwm_pkg::A_TB_CTRL:  s_d.rdata = s_q.tb_ctrl;
        mcpwm_pkg::A_TB_COUNT: s_d.rdata = {s_q.down, s_q.cnt};
        mcpwm_pkg::A_TB_PER:   s_d.rdata = {1'b0, s_q.per};
        mcpwm_pkg::A_CON_ONE:  s_d.rdata = s_q.con_one;
        mcpwm_pkg::A_FLT_A:    s_d.rdata = s_q.flt_a;
        mcpwm_pkg::A_FLT_B:    s_d.rdata = s_q.flt_b;
        mcpwm_pkg::A_DUTY1:    s_d.rdata = {1'b0, s_q.duty[0]};
        mcpwm_pkg::A_DUTY2:    s_d.rdata = {1'b0, s_q.duty[1]};
        mcpwm_pkg::A_DUTY3:    s_d.rdata = {1'b0, s_q.duty[2]};
        mcpwm_pkg::A_STATUS:   s_d.rdata = {11'h000, armed, s_q.act_b, s_q.act_a, s_q.flag_b, s_q.flag_a};
        default:               s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q         <= '0;
      s_q.con_one <= mcpwm_pkg::CON_ONE_RST;
      s_q.flt_a   <= mcpwm_pkg::FLT_RST;
      s_q.flt_b   <= mcpwm_pkg::FLT_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : mcpwm_core

// [testbench/mcpwm_chk.sv]
/* Port checker for the motor PWM core.
 Assumes binding to mcpwm_core and the bench keeping fault A and B enabled, overrides zero,
 and every pair in complementary mode. */
`timescale 1ns/1ns
module mcpwm_chk #(
  parameter int unsigned NPAIR = mcpwm_pkg::NPAIR
) (
  input wire logic                          sys_clk,
  input wire logic                          rst,
  input wire mcpwm_pkg::mcpwm_sfr_req_t     sfr_req,
  input wire logic [mcpwm_pkg::DATA_W-1:0]  sfr_rdata,
  input wire logic [15:0]                   oscillator_select_config_word,
  input wire logic                          cpu_idle,
  input wire logic                          fault_input_a_n,
  input wire logic                          fault_input_b_n,
  input wire logic                          fault_pins_owned,
  input wire logic [NPAIR-1:0]              high_side_output,
  input wire logic [NPAIR-1:0]              low_side_output,
  input wire logic [NPAIR-1:0]              high_side_enable,
  input wire logic [NPAIR-1:0]              low_side_enable,
  input wire logic                          time_base_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [2*NPAIR-1:0] outs;
  logic [2*NPAIR-1:0] ens;
  logic               key1;
  logic               key2;
  assign outs = {high_side_output, low_side_output};
  assign ens  = {high_side_enable, low_side_enable};
  assign key1 = sfr_req.wr && sfr_req.addr == mcpwm_pkg::A_KEY && sfr_req.wdata == mcpwm_pkg::KEY_FIRST;
  assign key2 = sfr_req.wr && sfr_req.addr == mcpwm_pkg::A_KEY && sfr_req.wdata == mcpwm_pkg::KEY_SECOND;

  AST_RST_OUT: assert property ($past(rst) |-> outs == '0)
    else $error("outputs not safe after reset");
  AST_OWN: assert property ($past(rst) |-> fault_pins_owned)
    else $error("fault pins not owned after reset");
  AST_FLT_A: assert property (!fault_input_a_n |-> ##2 outs == '0)
    else $error("fault a did not force outputs");
  AST_FLT_B: assert property (!fault_input_b_n |-> ##2 outs == '0)
    else $error("fault b did not force outputs");
  AST_NO_SHOOT: assert property ((high_side_output & low_side_output) == '0)
    else $error("both outputs of a pair high");
  AST_EN_CAUSE: assert property ($changed(ens) |-> $past(sfr_req.wr && sfr_req.addr == mcpwm_pkg::A_CON_ONE))
    else $error("enables changed without a write");
  AST_UNLOCK: assert property ($changed(ens) && oscillator_select_config_word[mcpwm_pkg::LOCK_CFG_BIT] |->
                               $past(key2, 2) && $past(key1, 3))
    else $error("protected write took effect without unlock");
  AST_TBE_PULSE: assert property (time_base_event |=> !time_base_event)
    else $error("time base event longer than one cycle");

  cover property (!fault_input_a_n ##2 outs == '0);
  cover property ($changed(ens) && oscillator_select_config_word[mcpwm_pkg::LOCK_CFG_BIT]);
  cover property (time_base_event);
endmodule : mcpwm_chk

bind mcpwm_core mcpwm_chk #(.NPAIR(NPAIR)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .oscillator_select_config_word(oscillator_select_config_word), .cpu_idle(cpu_idle),
  .fault_input_a_n(fault_input_a_n), .fault_input_b_n(fault_input_b_n), .fault_pins_owned(fault_pins_owned),
  .high_side_output(high_side_output), .low_side_output(low_side_output),
  .high_side_enable(high_side_enable), .low_side_enable(low_side_enable), .time_base_event(time_base_event));

// [testbench/mcpwm_stage_model.sv]
/* Power stage and fault wiring model.
 Assumes three complementary pairs and one clock. */
`timescale 1ns/1ns
module mcpwm_stage_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] high_side_output,
  input  wire logic [2:0] low_side_output,
  input  wire logic       trip_a,
  input  wire logic       wired,
  output logic            fault_input_a_n,
  output logic            fault_input_b_n,
  output logic            shoot_seen
);
  // Broken wiring lets the pull-down assert both faults; high clears
  assign fault_input_a_n = wired & ~trip_a;
  assign fault_input_b_n = wired;
  initial shoot_seen = 1'b0;
  always @(posedge sys_clk) begin
    if ((high_side_output & low_side_output) != 3'h0) begin
      shoot_seen <= 1'b1;
    end
  end
endmodule : mcpwm_stage_model

// [testbench/test_motor_pwm_fault_and_write_lock.sv]
/* Self-checking bench for the motor PWM core.
 Assumes the stage model on the far side and the bound port checker. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_motor_pwm_fault_and_write_lock;
  logic                      sys_clk, rst, cpu_idle, owned, tbe, trip_a, wired, shoot, fa_n, fb_n;
  logic [15:0]               rdata;
  logic [15:0]               cfg;
  logic [2:0]                hi, lo, hen, len;
  mcpwm_pkg::mcpwm_sfr_req_t req;
  int                        num_errors = 0;
  int                        n_checks = 0;

  mcpwm_core #(.NPAIR(3)) dut (.sys_clk(sys_clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
    .oscillator_select_config_word(cfg), .cpu_idle(cpu_idle), .fault_input_a_n(fa_n), .fault_input_b_n(fb_n),
    .fault_pins_owned(owned), .high_side_output(hi), .low_side_output(lo), .high_side_enable(hen),
    .low_side_enable(len), .time_base_event(tbe));
  mcpwm_stage_model u_stage (.sys_clk(sys_clk), .high_side_output(hi), .low_side_output(lo), .trip_a(trip_a),
    .wired(wired), .fault_input_a_n(fa_n), .fault_input_b_n(fb_n), .shoot_seen(shoot));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    req = '{wr: w, rd: r, addr: a, wdata: d};
    tick();
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, a, d);
    req = '0;
    tick();
  endtask : wr
  task automatic unlock_wr(input logic [3:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, mcpwm_pkg::A_KEY, mcpwm_pkg::KEY_FIRST);
    acc(1'b1, 1'b0, mcpwm_pkg::A_KEY, mcpwm_pkg::KEY_SECOND);
    wr(a, d);
  endtask : unlock_wr
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
    acc(1'b0, 1'b1, a, 16'h0000);
    req = '0;
    `CHK(nm, e, rdata)
    tick();
  endtask : rd_chk
  task automatic wait_tbe(input int lim, input bit must, output int n);
    n = 0;
    while (tbe !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    if (must && n >= lim) begin
      num_errors++;
      $display("mismatch time_base_event wait bound");
      wrap_up();
    end
  endtask : wait_tbe

  task automatic t_lock();
    `CHK("owned after reset", 1'b1, owned)
    rd_chk("flt_a rst", mcpwm_pkg::A_FLT_A, mcpwm_pkg::FLT_RST);
    rd_chk("flt_b rst", mcpwm_pkg::A_FLT_B, mcpwm_pkg::FLT_RST);
    rd_chk("unmapped", 4'hf, 16'h0000);
    wr(mcpwm_pkg::A_CON_ONE, 16'h0077);
    rd_chk("no key", mcpwm_pkg::A_CON_ONE, 16'h0000);
    acc(1'b1, 1'b0, mcpwm_pkg::A_KEY, mcpwm_pkg::KEY_FIRST);
    acc(1'b0, 1'b1, mcpwm_pkg::A_STATUS, 16'h0000);
    acc(1'b1, 1'b0, mcpwm_pkg::A_KEY, mcpwm_pkg::KEY_SECOND);
    wr(mcpwm_pkg::A_CON_ONE, 16'h0077);
    rd_chk("broken seq", mcpwm_pkg::A_CON_ONE, 16'h0000);
    acc(1'b1, 1'b0, mcpwm_pkg::A_KEY, mcpwm_pkg::KEY_SECOND);
    acc(1'b1, 1'b0, mcpwm_pkg::A_KEY, mcpwm_pkg::KEY_FIRST);
    wr(mcpwm_pkg::A_CON_ONE, 16'h0077);
    rd_chk("swapped keys", mcpwm_pkg::A_CON_ONE, 16'h0000);
    // Faults cleared before the outputs are enabled
    unlock_wr(mcpwm_pkg::A_FLT_A, 16'h0001);
    unlock_wr(mcpwm_pkg::A_FLT_B, 16'h0001);
    rd_chk("status clear", mcpwm_pkg::A_STATUS, 16'h0000);
    unlock_wr(mcpwm_pkg::A_CON_ONE, 16'h0077);
    rd_chk("unlocked", mcpwm_pkg::A_CON_ONE, 16'h0077);
    `CHK("enables", 6'h3f, {hen, len})
    wr(mcpwm_pkg::A_CON_ONE, 16'h0000);
    rd_chk("one grant", mcpwm_pkg::A_CON_ONE, 16'h0077);
    $display("done lock");
  endtask : t_lock

  task automatic t_run();
    int c0, c1, c2;
    c0 = 0; c1 = 0; c2 = 0;
    wr(mcpwm_pkg::A_TB_PER, 16'h0007);
    wr(mcpwm_pkg::A_DUTY1, 16'h0003);
    wr(mcpwm_pkg::A_DUTY2, 16'h0005);
    wr(mcpwm_pkg::A_DUTY3, 16'h0000);
    wr(mcpwm_pkg::A_TB_CTRL, 16'h8000);
    repeat (4) tick();
    for (int i = 0; i < 16; i++) begin
      `CHK("complement", ~hi, lo)
      c0 += hi[0]; c1 += hi[1]; c2 += hi[2];
      tick();
    end
    `CHK("duty1", 6, c0)
    `CHK("duty2", 10, c1)
    `CHK("duty3", 0, c2)
    `CHK("shoot", 1'b0, shoot)
    $display("done run");
  endtask : t_run

  task automatic t_fault();
    int  n;
    bit  seen;
    trip_a = 1'b1;
    repeat (3) tick();
    `CHK("forced a", 6'h00, {hi, lo})
    trip_a = 1'b0;
    repeat (20) tick();
    `CHK("latched", 6'h00, {hi, lo})
    wired = 1'b0;
    repeat (3) tick();
    `CHK("forced b", 6'h00, {hi, lo})
    wired = 1'b1;
    tick();
    wr(mcpwm_pkg::A_STATUS, 16'h0003);
    n = 0;
    seen = 1'b0;
    while ({hi, lo} === 6'h00 && n < 40) begin
      seen |= tbe;
      tick();
      n++;
    end
    seen |= tbe;
    tick();
    seen |= tbe;
    if (n >= 40) begin
      num_errors++;
      $display("mismatch restore wait bound");
      wrap_up();
    end
    `CHK("boundary", 1'b1, seen)
    $display("done fault");
  endtask : t_fault

  task automatic t_base();
    int n;
    for (int k = 0; k < 3; k++) begin
      logic [3:0] code;
      code = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : 4'hf;
      wr(mcpwm_pkg::A_TB_CTRL, {8'h80, code, 4'h0});
      wait_tbe(300, 1'b1, n);
      tick();
      wait_tbe(300, 1'b1, n);
      `CHK("postscale", (code + 1) * 8, n + 1)
    end
    cpu_idle = 1'b1;
    wr(mcpwm_pkg::A_TB_CTRL, 16'ha000);
    repeat (2) tick();
    wait_tbe(40, 1'b0, n);
    `CHK("idle halt", 40, n)
    wr(mcpwm_pkg::A_TB_CTRL, 16'h8000);
    wait_tbe(40, 1'b1, n);
    cpu_idle = 1'b0;
    cfg = 16'h0000;
    wr(mcpwm_pkg::A_CON_ONE, 16'h0070);
    rd_chk("lock off", mcpwm_pkg::A_CON_ONE, 16'h0070);
    `CHK("enables lock off", 6'h38, {hen, len})
    cfg = 16'h0040;
    $display("done base");
  endtask : t_base

  task automatic t_mode();
    int n;
    wr(mcpwm_pkg::A_TB_CTRL, 16'h8002);
    wait_tbe(300, 1'b1, n);
    tick();
    wait_tbe(300, 1'b1, n);
    `CHK("up down", 14, n + 1)
    wr(mcpwm_pkg::A_TB_CTRL, 16'h8004);
    wait_tbe(300, 1'b1, n);
    tick();
    wait_tbe(300, 1'b1, n);
    `CHK("prescale", 32, n + 1)
    wr(mcpwm_pkg::A_TB_CTRL, 16'h8001);
    wait_tbe(300, 1'b1, n);
    tick();
    rd_chk("single shot", mcpwm_pkg::A_TB_CTRL, 16'h0001);
    $display("done mode");
  endtask : t_mode

  initial begin
    req = '0;
    cfg = 16'h0040;
    cpu_idle = 1'b0;
    trip_a = 1'b0;
    wired = 1'b1;
    rst = 1'b1;
    repeat (3) tick();
    `CHK("owned in reset", 1'b1, owned)
    repeat (2) tick();
    rst = 1'b0;
    t_lock();
    t_run();
    t_fault();
    t_base();
    t_mode();
    wrap_up();
  end
endmodule : test_motor_pwm_fault_and_write_lock
